// *** hw/btc_ctrl.sv ***
/*
  Digital control of a single-channel bus transceiver: mode control, driver and
  receiver truth tables, transmit-enable timeout, remote wakeup and serial status.
  Assumes the analog front end delivers the decoded bus symbol and the supply,
  thermal and bus error levels, all synchronous to i_clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none

module btc_ctrl
  import btc_pkg::*;
#(
  parameter int TX_MAX_CYC = TX_ACTIVE_MAX_CYC,
  parameter int WU_D0_CYC = ns_up(WU_D0_MIN_NS),
  parameter int WU_GAP_CYC = ns_up(WU_GAP_MIN_NS),
  parameter int WU_GAP_MAX_CYC = ns_dn(WU_GAP_MAX_NS),
  parameter int WU_FILT_CYC = ns_dn(WU_FILT_NS),
  parameter logic [7:0] ANALOG_VER = 8'h01, // Arbitrary value.
  parameter logic [7:0] DIGITAL_VER = 8'h01 // Arbitrary value.
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Controller and guardian pins.
  input wire logic i_tx_data,
  input wire logic i_tx_enable_n,
  input wire logic i_guardian_enable,
  input wire logic i_mode_select_n,
  // Analog front end.
  input wire btc_sym_t i_bus_rx_sym,
  input wire logic i_vcc_uv,
  input wire logic i_vio_uv,
  input wire logic i_thermal,
  input wire logic i_bus_error,
  // Serial status port.
  input wire logic i_chip_select_n,
  input wire logic i_serial_clk,
  output logic o_serial_out,
  output logic o_serial_out_en,
  // Bus side and receiver control.
  output btc_sym_t o_bus_drive,
  output logic o_rx_data,
  output logic o_normal_rx_en,
  output logic o_lp_rx_en
);

  btc_state_t s_r;
  btc_state_t s_nxt;

  // Status word with bit 3 and parity filled in at shift time.
  function automatic logic [STAT_W-1:0] finish_word(input logic [STAT_W-1:0] w,
                                                    input logic ge);
    logic [STAT_W-1:0] f;
    f = w;
    f[S_GEFB] = ge;
    f[S_PAR] = ^f[S_PAR-1:0];
    return f;
  endfunction

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic is_d0;
  logic tx_on;
  logic [STAT_W-1:0] snap;
  logic [STAT_W-1:0] shown;

  // Serial port edges; the pins are already synchronous so no extra stages.
  assign sck_rise = i_serial_clk && !s_r.sck_d && !i_chip_select_n;
  assign sck_fall = !i_serial_clk && s_r.sck_d && !i_chip_select_n;
  assign cs_fall = !i_chip_select_n && s_r.cs_n_d;
  assign cs_rise = i_chip_select_n && !s_r.cs_n_d;
  assign is_d0 = (i_bus_rx_sym == SYM_D0);
  assign tx_on = s_r.tx_act && !s_r.tx_to;
  assign shown = finish_word(s_r.word, s_r.ge_smp);

  // Snapshot of the status word taken as chip select falls.
  always_comb begin
    snap = '0;
    snap[S_WAKE] = s_r.wake;
    snap[S_MODE] = s_r.normal;
    snap[S_TXRDY] = s_r.normal && tx_on;
    snap[S_SPIERR:S_PWRON] = s_r.lat;
    snap[S_PAR-1:S_FIX_LO] = FIXED_BITS;
    snap[S_DVER-1:S_AVER] = ANALOG_VER;
    snap[STAT_W-1:S_DVER] = DIGITAL_VER;
  end

  // Next-state logic of the whole block.
  always_comb begin
    logic wake_set;
    logic glitch_end;
    logic frame_ok;
    btc_latch_t hold;
    wake_set = 1'b0;
    glitch_end = 1'b0;
    frame_ok = 1'b0;
    hold = '0;
    s_nxt = s_r;
    s_nxt.cs_n_d = i_chip_select_n;
    s_nxt.sck_d = i_serial_clk;
    s_nxt.tx_enable_n_n_d = i_tx_enable_n;
    s_nxt.vcc_uv_in = i_vcc_uv;
    s_nxt.vio_uv_in = i_vio_uv;

    // Wakeup detector runs in both modes so a pattern may span a mode change.
    // Short interruptions of a phase are filtered, which lets the frame's
    // long Data_0 and Data_1 blocks, broken by byte framing, pass as a pattern.
    case (s_r.wk)
      WK_IDLE: begin
        s_nxt.wk_cnt = '0;
        s_nxt.wk_glitch = '0;
        if (is_d0) begin
          s_nxt.wk = WK_D0A;
        end
      end
      WK_D0A, WK_D0B: begin
        if (is_d0) begin
          s_nxt.wk_glitch = '0;
          if (s_r.wk_cnt != 16'hffff) begin
            s_nxt.wk_cnt = s_r.wk_cnt + 16'h1;
          end
        end else begin
          s_nxt.wk_glitch = s_r.wk_glitch + 8'h1;
          glitch_end = (32'(s_r.wk_glitch) >= WU_FILT_CYC);
        end
        if (32'(s_r.wk_cnt) >= WU_D0_CYC && s_r.wk == WK_D0B) begin
          s_nxt.wk = WK_IDLE;
          wake_set = !s_r.normal && !s_r.vcc_uv;
        end else if (glitch_end) begin
          s_nxt.wk_cnt = '0;
          s_nxt.wk_glitch = '0;
          s_nxt.wk = (32'(s_r.wk_cnt) >= WU_D0_CYC && s_r.wk == WK_D0A) ? WK_GAP : WK_IDLE;
        end
      end
      WK_GAP: begin
        // Idle or Data_1 both count as separator.
        s_nxt.wk_cnt = s_r.wk_cnt + 16'h1;
        if (is_d0) begin
          // A short Data_0, such as a frame's byte start, does not end the separator.
          s_nxt.wk_glitch = s_r.wk_glitch + 8'h1;
          if (32'(s_r.wk_glitch) >= WU_FILT_CYC) begin
            s_nxt.wk_cnt = '0;
            s_nxt.wk_glitch = '0;
            s_nxt.wk = (32'(s_r.wk_cnt) >= WU_GAP_CYC) ? WK_D0B : WK_D0A;
          end
        end else begin
          s_nxt.wk_glitch = '0;
          if (32'(s_r.wk_cnt) >= WU_GAP_MAX_CYC) begin
            s_nxt.wk = WK_IDLE;
          end
        end
      end
      default: begin
        s_nxt.wk = WK_IDLE;
      end
    endcase

    // Wake flag is cleared by entering Normal; a new wake wins.
    if (s_r.normal) begin
      s_nxt.wake = 1'b0;
    end
    if (wake_set) begin
      s_nxt.wake = 1'b1;
    end

    // Under-voltage flags set on the falling supply, clear on recovery; a wake clears both flags.
    if (!i_vcc_uv || wake_set) begin
      s_nxt.vcc_uv = 1'b0;
    end
    if (!i_vio_uv || wake_set) begin
      s_nxt.vio_uv = 1'b0;
    end
    if (i_vcc_uv && !s_r.vcc_uv_in) begin
      s_nxt.vcc_uv = 1'b1;
    end
    if (i_vio_uv && !s_r.vio_uv_in) begin
      s_nxt.vio_uv = 1'b1;
    end

    // Mode: select high asks for Normal unless a supply flag forces Standby.
    // After a wake the mode select must still be raised to leave Standby.
    s_nxt.normal = i_mode_select_n && !s_nxt.vcc_uv && !s_nxt.vio_uv;
    if (wake_set) begin
      s_nxt.normal = 1'b0;
    end

    // Transmitter activation, start condition and timeout.
    if (!i_tx_enable_n && s_r.tx_enable_n_n_d && s_r.normal) begin
      s_nxt.tx_act = 1'b1;
      s_nxt.tx_started = 1'b0;
    end
    if (s_nxt.tx_act && !s_r.tx_started && !i_tx_data) begin
      s_nxt.tx_started = 1'b1;
    end
    // A guardian cut ends the burst, so driving resumes only with Data_0.
    if (!i_guardian_enable) begin
      s_nxt.tx_started = 1'b0;
    end
    if (!i_tx_enable_n && s_r.normal) begin
      if (32'(s_r.tx_cnt) >= TX_MAX_CYC) begin
        s_nxt.tx_to = 1'b1;
      end else begin
        s_nxt.tx_cnt = s_r.tx_cnt + 16'h1;
      end
    end
    if (i_tx_enable_n || !s_r.normal) begin
      s_nxt.tx_cnt = '0;
      s_nxt.tx_act = 1'b0;
      s_nxt.tx_started = 1'b0;
    end
    if (i_tx_enable_n) begin
      s_nxt.tx_to = 1'b0;
    end

    // Bus drive and receive output, registered.
    if (!s_nxt.normal) begin
      s_nxt.drive = SYM_IDLE_LP;
      s_nxt.rxd = !s_nxt.wake;
    end else begin
      s_nxt.drive = SYM_IDLE;
      if (i_guardian_enable && !i_tx_enable_n && s_nxt.tx_act && !s_nxt.tx_to &&
          s_nxt.tx_started) begin
        s_nxt.drive = i_tx_data ? SYM_D1 : SYM_D0;
      end
      s_nxt.rxd = !is_d0;
    end

    // Two-entry buffer of status snapshots between capture and shifter.
    if (s_r.buf_v[s_r.rd_ptr] && !s_r.loaded) begin
      s_nxt.word = s_r.buf_q[s_r.rd_ptr];
      s_nxt.buf_v[s_r.rd_ptr] = 1'b0;
      s_nxt.rd_ptr = !s_r.rd_ptr;
      s_nxt.loaded = 1'b1;
      s_nxt.serial_out = s_r.buf_q[s_r.rd_ptr][S_WAKE];
    end
    if (cs_fall && !s_r.buf_v[s_r.wr_ptr]) begin
      s_nxt.buf_q[s_r.wr_ptr] = snap;
      s_nxt.buf_v[s_r.wr_ptr] = 1'b1;
      s_nxt.wr_ptr = !s_r.wr_ptr;
      s_nxt.falls = '0;
    end

    // Shifting: next bit on each rising edge, count falling edges.
    if (sck_fall) begin
      if (s_r.falls == 6'(S_TXRDY)) begin
        s_nxt.ge_smp = s_r.normal && i_guardian_enable;
      end
      if (s_r.falls != 6'h3f) begin
        s_nxt.falls = s_r.falls + 6'h1;
      end
    end
    if (sck_rise && s_r.loaded && s_r.falls < 6'(STAT_W)) begin
      s_nxt.serial_out = shown[s_r.falls[4:0]];
    end
    s_nxt.sdo_en = !i_chip_select_n;

    // Latched status bits follow their flags; set wins over clear.
    hold.pwr_on = 1'b0;
    hold.bus_err = i_bus_error;
    hold.therm = i_thermal;
    hold.tx_to = s_r.tx_to;
    hold.vcc_uv = s_r.vcc_uv;
    hold.vio_uv = s_r.vio_uv;
    hold.spi_err = 1'b0;
    if (cs_rise && s_r.loaded) begin
      frame_ok = (s_r.falls == FRAME_OK_FALLS);
      s_nxt.loaded = 1'b0;
      if (frame_ok) begin
        s_nxt.lat = hold;
      end else begin
        s_nxt.lat.spi_err = 1'b1;
      end
    end
    s_nxt.lat = s_nxt.lat | hold;
  end

  // State register; power-on status is set by reset.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_r <= '0;
      s_r.lat.pwr_on <= 1'b1;
      s_r.cs_n_d <= 1'b1;
      s_r.tx_enable_n_n_d <= 1'b1;
      s_r.drive <= SYM_IDLE_LP;
      s_r.rxd <= 1'b1;
      s_r.wk <= WK_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign o_serial_out = s_r.serial_out;
  assign o_serial_out_en = s_r.sdo_en;
  assign o_bus_drive = s_r.drive;
  assign o_rx_data = s_r.rxd;
  assign o_normal_rx_en = s_r.normal;
  assign o_lp_rx_en = !s_r.normal;

endmodule // btc_ctrl

`default_nettype wire

// *** hw/btc_pkg.sv ***
/*
  Shared constants, encodings and state types of the transceiver control logic.
  Assumes a single 20 MHz system clock; all pin levels arrive already synchronous to it.
*/
package btc_pkg;

  // System clock rate and the timing figures that depend on it.
  localparam int CLK_MHZ = 20;
  localparam int TX_ACTIVE_MAX_NS = 1500000;
  localparam int WU_D0_MIN_NS = 1000;
  localparam int WU_GAP_MIN_NS = 1000;
  localparam int WU_GAP_MAX_NS = 48000;
  localparam int WU_FILT_NS = 200;

  // Least time rounds up, never below one cycle.
  function automatic int ns_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time rounds down, never below one cycle.
  function automatic int ns_dn(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int TX_ACTIVE_MAX_CYC = ns_dn(TX_ACTIVE_MAX_NS);

  // Status word layout.
  localparam int STAT_W = 32;
  localparam int S_WAKE = 0;
  localparam int S_MODE = 1;
  localparam int S_TXRDY = 2;
  localparam int S_GEFB = 3;
  localparam int S_PWRON = 4;
  localparam int S_BUSERR = 5;
  localparam int S_THERM = 6;
  localparam int S_TXTO = 7;
  localparam int S_VCCUV = 8;
  localparam int S_VIOUV = 9;
  localparam int S_SPIERR = 10;
  localparam int S_FIX_LO = 11;
  localparam int S_PAR = 15;
  localparam int S_AVER = 16;
  localparam int S_DVER = 24;
  localparam logic [3:0] FIXED_BITS = 4'ha;
  localparam logic [5:0] FRAME_OK_FALLS = 6'h10;

  // Bus symbols, both seen by the receiver and sent by the driver.
  typedef enum logic [1:0] {
    SYM_IDLE = 2'h0,
    SYM_D0 = 2'h1,
    SYM_D1 = 2'h2,
    SYM_IDLE_LP = 2'h3
  } btc_sym_t;

  // Wakeup pattern detector, Gray coded along the pattern.
  typedef enum logic [1:0] {
    WK_IDLE = 2'h0,
    WK_D0A = 2'h1,
    WK_GAP = 2'h3,
    WK_D0B = 2'h2
  } btc_wk_t;

  // Latched status bits S4 to S10.
  typedef struct packed {
    logic spi_err;
    logic vio_uv;
    logic vcc_uv;
    logic tx_to;
    logic therm;
    logic bus_err;
    logic pwr_on;
  } btc_latch_t;

  // Whole state of the control block.
  typedef struct packed {
    logic normal;
    logic wake;
    logic vcc_uv;
    logic vio_uv;
    logic vcc_uv_in;
    logic vio_uv_in;
    logic tx_enable_n_n_d;
    logic tx_act;
    logic tx_started;
    logic tx_to;
    logic [15:0] tx_cnt;
    btc_wk_t wk;
    logic [15:0] wk_cnt;
    logic [7:0] wk_glitch;
    btc_latch_t lat;
    logic cs_n_d;
    logic sck_d;
    logic [1:0][STAT_W-1:0] buf_q;
    logic [1:0] buf_v;
    logic wr_ptr;
    logic rd_ptr;
    logic loaded;
    logic [STAT_W-1:0] word;
    logic [5:0] falls;
    logic ge_smp;
    logic serial_out;
    logic sdo_en;
    btc_sym_t drive;
    logic rxd;
  } btc_state_t;

endpackage

// *** verif/btc_ctrl_monitor.sv ***
/*
  Port-level checker for the transceiver control block, bound to btc_ctrl.
  Assumes the single system clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module btc_ctrl_monitor
  import btc_pkg::*;
#(
  parameter int TX_MAX_CYC = 50
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Inputs seen by the block.
  input wire logic i_tx_data,
  input wire logic i_tx_enable_n,
  input wire logic i_guardian_enable,
  input wire logic i_mode_select_n,
  input wire btc_sym_t i_bus_rx_sym,
  input wire logic i_vcc_uv,
  input wire logic i_vio_uv,
  input wire logic i_thermal,
  input wire logic i_bus_error,
  input wire logic i_chip_select_n,
  input wire logic i_serial_clk,
  // Outputs driven by the block.
  input wire logic o_serial_out,
  input wire logic o_serial_out_en,
  input wire btc_sym_t o_bus_drive,
  input wire logic o_rx_data,
  input wire logic o_normal_rx_en,
  input wire logic o_lp_rx_en
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  logic [15:0] low_cnt_r;

  // Counts Normal cycles with transmit enable held; saturates so it never wraps back.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_tx_enable_n || !o_normal_rx_en) low_cnt_r <= 16'h0;
    else if (low_cnt_r != 16'hffff) low_cnt_r <= low_cnt_r + 16'h1;
  end

  // A transmission opens when the driver leaves the idle levels.
  sequence tx_start;
    o_bus_drive inside {SYM_IDLE, SYM_IDLE_LP} ##1 o_bus_drive inside {SYM_D0, SYM_D1};
  endsequence

  rx_paths_a: assert property (o_normal_rx_en != o_lp_rx_en)
    else $error("receiver enables not complementary");
  out_enable_a: assert property (o_serial_out_en == !$past(i_chip_select_n))
    else $error("serial output enable does not follow chip select");
  guard_off_a: assert property (o_normal_rx_en && !i_guardian_enable
    |=> !(o_bus_drive inside {SYM_D0, SYM_D1})) else $error("driving with guardian off");
  tx_enable_n_off_a: assert property (i_tx_enable_n
    |=> !(o_bus_drive inside {SYM_D0, SYM_D1})) else $error("driving with enable high");
  standby_drive_a: assert property (!o_normal_rx_en [*2] |-> o_bus_drive == SYM_IDLE_LP)
    else $error("standby drive not low-power idle");
  first_symbol_a: assert property (tx_start |-> o_bus_drive == SYM_D0)
    else $error("transmission opened with Data_1");
  data_map_a: assert property (o_bus_drive inside {SYM_D0, SYM_D1} |->
    o_bus_drive == ($past(i_tx_data) ? SYM_D1 : SYM_D0) && $past(i_guardian_enable)
    && !$past(i_tx_enable_n)) else $error("bus symbol does not match inputs");
  rx_normal_a: assert property (o_normal_rx_en && $past(o_normal_rx_en)
    |-> o_rx_data == ($past(i_bus_rx_sym) != SYM_D0)) else $error("receive output wrong");
  tx_timeout_a: assert property (low_cnt_r > TX_MAX_CYC + 2
    |-> !(o_bus_drive inside {SYM_D0, SYM_D1})) else $error("transmit enable timeout missed");
endmodule // btc_ctrl_monitor

bind btc_ctrl btc_ctrl_monitor #(.TX_MAX_CYC(TX_MAX_CYC)) mon_u (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_tx_data(i_tx_data),
  .i_tx_enable_n(i_tx_enable_n), .i_guardian_enable(i_guardian_enable),
  .i_mode_select_n(i_mode_select_n), .i_bus_rx_sym(i_bus_rx_sym), .i_vcc_uv(i_vcc_uv),
  .i_vio_uv(i_vio_uv), .i_thermal(i_thermal), .i_bus_error(i_bus_error),
  .i_chip_select_n(i_chip_select_n), .i_serial_clk(i_serial_clk),
  .o_serial_out(o_serial_out), .o_serial_out_en(o_serial_out_en),
  .o_bus_drive(o_bus_drive), .o_rx_data(o_rx_data), .o_normal_rx_en(o_normal_rx_en),
  .o_lp_rx_en(o_lp_rx_en));

`default_nettype wire

// *** verif/btc_bus_node.sv ***
/*
  Remote node on the bus: sends one wakeup pattern per request.
  Assumes the decoded symbol is read by the block on the next rising edge.
*/
`timescale 1ns/100ps
`default_nettype none

module btc_bus_node
  import btc_pkg::*;
(
  // Clock and request.
  input wire logic i_clk_sys,
  input wire logic i_send,
  input wire btc_sym_t i_gap_sym,
  // Decoded bus symbol.
  output var btc_sym_t o_sym
);
  logic [6:0] pos_r = 7'h0;

  // Counts down through Data_0, separator and Data_0, each well inside the detector window.
  always_ff @(posedge i_clk_sys) begin
    if (i_send) pos_r <= 7'h5a;
    else if (pos_r != 7'h0) pos_r <= pos_r - 7'h1;
  end

  // Outside a pattern the bus rests at Idle.
  always_comb begin
    // One-cycle breaks mimic a frame's byte framing, which the detector must ride over.
    if (pos_r == 7'h0) o_sym = SYM_IDLE;
    else if (pos_r == 7'h0f) o_sym = i_gap_sym;
    else if (pos_r == 7'h2d) o_sym = SYM_D0;
    else if (pos_r > 7'h3c || pos_r < 7'h1f) o_sym = SYM_D0;
    else o_sym = i_gap_sym;
  end
endmodule // btc_bus_node

`default_nettype wire

// *** verif/btc_ctrl_tb.sv ***
/*
  Self-checking testbench of the transceiver control block.
  Assumes a short transmit timeout parameter and the default wakeup timing.
*/
`timescale 1ns/100ps
`default_nettype none

module btc_ctrl_tb;
  import btc_pkg::*;
  localparam int TXMAX = 50;
  logic clk = 0, rst = 1, txd = 1, tx_enable_n_n = 1, ge = 0, msel = 0, vcc = 0, vio = 0;
  logic therm = 0, berr = 0, cs_n = 1, sck = 0, send = 0;
  logic serial_out, sdo_en, rxd, nrx, lrx;
  btc_sym_t gap = SYM_IDLE;
  btc_sym_t rx_sym, drv;
  int mismatches = 0;
  int n_tests = 0;
  logic [31:0] w;
  logic [6:0] exp_lat [4] = '{7'h41, 7'h04, 7'h04, 7'h00};

  // Free-running system clock.
  always #25 clk = ~clk;

  btc_ctrl #(.TX_MAX_CYC(TXMAX), .ANALOG_VER(8'h5a), .DIGITAL_VER(8'hc3)) dut_u (
    .i_clk_sys(clk), .i_reset(rst), .i_tx_data(txd), .i_tx_enable_n(tx_enable_n_n),
    .i_guardian_enable(ge), .i_mode_select_n(msel), .i_bus_rx_sym(rx_sym),
    .i_vcc_uv(vcc), .i_vio_uv(vio), .i_thermal(therm), .i_bus_error(berr),
    .i_chip_select_n(cs_n), .i_serial_clk(sck), .o_serial_out(serial_out),
    .o_serial_out_en(sdo_en), .o_bus_drive(drv), .o_rx_data(rxd),
    .o_normal_rx_en(nrx), .o_lp_rx_en(lrx));

  btc_bus_node node_u (.i_clk_sys(clk), .i_send(send), .i_gap_sym(gap), .o_sym(rx_sym));

  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Serial clock phases of three system cycles keep every edge well sampled.
  task automatic read(input int nb, output logic [31:0] v);
    v = '0;
    cs_n = 0;
    cyc(3);
    for (int i = 0; i < nb; i++) begin
      sck = 1;
      cyc(3);
      v[i] = serial_out; // Bit i leaves on rising edge number i plus one.
      sck = 0;
      cyc(3);
    end
    cs_n = 1;
    cyc(3);
  endtask

  // Bounded wait for the receive output; running out ends the run.
  task automatic wait_rx(input logic v);
    int k;
    for (k = 0; k < 200 && rxd !== v; k++) cyc(1);
    if (k == 200) begin
      mismatches++;
      finish_test();
    end
  endtask

  task automatic pattern();
    send = 1;
    cyc(1);
    send = 0;
  endtask

  // Main sequence: status port, driver, mode control, then wakeup.
  initial begin
    cyc(12);
    rst = 0;
    cyc(1);
    check({drv, rxd, nrx, lrx}, {SYM_IDLE_LP, 3'b101});
    read(32, w);
    check({w[31:11], w[3:1]}, {16'hc35a, ^w[14:0], 4'ha, 3'h0});
    for (int j = 0; j < 4; j++) begin
      therm = (j == 1);
      cyc(2);
      read(16, w);
      check({w[15], w[10:4]}, {^w[14:0], exp_lat[j]});
    end
    ge = 1;
    tx_enable_n_n = 0;
    cyc(2);
    msel = 1;
    cyc(3);
    check({nrx, lrx, drv}, {2'b10, SYM_IDLE});
    tx_enable_n_n = 1;
    cyc(2);
    tx_enable_n_n = 0;
    cyc(2);
    check(drv, SYM_IDLE);
    txd = 0;
    cyc(2);
    check(drv, SYM_D0);
    txd = 1;
    cyc(2);
    check(drv, SYM_D1);
    ge = 0;
    cyc(2);
    check(drv, SYM_IDLE);
    ge = 1;
    cyc(TXMAX);
    check(drv, SYM_IDLE);
    read(16, w);
    check({w[7], w[3:1]}, 4'hd);
    tx_enable_n_n = 1;
    cyc(2);
    tx_enable_n_n = 0;
    txd = 0;
    cyc(2);
    check(drv, SYM_D0);
    tx_enable_n_n = 1;
    vcc = 1;
    cyc(3);
    check({nrx, drv}, {1'b0, SYM_IDLE_LP});
    vcc = 0;
    cyc(3);
    check(nrx, 1'b1);
    pattern();
    cyc(10);
    check(rxd, 1'b0);
    msel = 0;
    cyc(40);
    check({rxd, lrx}, 2'b11);
    wait_rx(1'b0);
    msel = 1;
    cyc(3);
    msel = 0;
    cyc(3);
    check(rxd, 1'b1);
    gap = SYM_D1;
    vio = 1;
    pattern();
    wait_rx(1'b0);
    check({rxd, lrx}, 2'b01);
    msel = 1;
    cyc(3);
    check(nrx, 1'b1);
    vio = 0;
    msel = 0;
    vcc = 1;
    pattern();
    cyc(100);
    check({rxd, nrx}, 2'b10);
    vcc = 0;
    finish_test();
  end
endmodule // btc_ctrl_tb

`default_nettype wire
